//--- hdl/ssrg_group.v
// One status group: condition, transition filters, sticky event, enable, summary
`timescale 1ns/1ps
module ssrg_group #(
   parameter [15:0] LIVE = 16'h0000
) (
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire        i_ce,
   input  wire [15:0] i_cond,
   input  wire        i_init,
   input  wire        i_preset,
   input  wire        i_clear,
   input  wire        i_ev_read,
   input  wire        i_wr_enable,
   input  wire        i_wr_fall,
   input  wire        i_wr_rise,
   input  wire [15:0] i_wdata,
   output reg  [15:0] o_cond,
   output reg  [15:0] o_event,
   output reg  [15:0] o_enable,
   output reg  [15:0] o_fall,
   output reg  [15:0] o_rise,
   output wire        o_summary
);
`include "ssrg_map.vh"

   wire [15:0] live_cond;
   wire [15:0] hits;
   wire [15:0] wval;

   assign live_cond = i_cond & LIVE;
   // Rising edge via rise filter, falling edge via fall filter
   assign hits = ((live_cond & ~o_cond) & o_rise) | ((~live_cond & o_cond) & o_fall);
   assign wval = i_wdata & `SSRG_WMASK;
   assign o_summary = |(o_event & o_enable);

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cond   <= `SSRG_ZERO;
         o_event  <= `SSRG_ZERO;
         o_enable <= `SSRG_ZERO;
         o_fall   <= `SSRG_ZERO;
         o_rise   <= `SSRG_ZERO;
      end else if (i_ce) begin
         o_cond <= live_cond;
         // Set beats clear so an edge in the read cycle is kept for the next read
         if (i_ev_read || i_clear) begin
            o_event <= hits;
         end else begin
            o_event <= o_event | hits;
         end
         if (i_init) begin
            o_enable <= `SSRG_ZERO;
            o_fall   <= `SSRG_ZERO;
            o_rise   <= `SSRG_ZERO;
         end else if (i_preset) begin
            o_enable <= `SSRG_ZERO;
            o_fall   <= `SSRG_ZERO;
            o_rise   <= `SSRG_ONES;
         end else begin
            if (i_wr_enable) begin
               o_enable <= wval;
            end
            if (i_wr_fall) begin
               o_fall <= wval;
            end
            if (i_wr_rise) begin
               o_rise <= wval;
            end
         end
      end
   end
endmodule // ssrg_group

//--- hdl/ssrg_map.vh
// Register indices, live bit masks and reset values of the status register groups
`ifndef SSRG_MAP_VH
`define SSRG_MAP_VH

`define SSRG_W            16
`define SSRG_AW           4
// Register indices on the command port
`define SSRG_OP_COND      4'h0
`define SSRG_OP_EVENT     4'h1
`define SSRG_OP_ENABLE    4'h2
`define SSRG_OP_FALL      4'h3
`define SSRG_OP_RISE      4'h4
`define SSRG_QU_COND      4'h5
`define SSRG_QU_EVENT     4'h6
`define SSRG_QU_ENABLE    4'h7
`define SSRG_QU_FALL      4'h8
`define SSRG_QU_RISE      4'h9
// Live condition positions
`define SSRG_OP_LIVE      16'h1F01
`define SSRG_QU_LIVE      16'h0064
// Operation condition bit positions
`define SSRG_B_CAL        0
`define SSRG_B_STANDBY    8
`define SSRG_B_BATTERY    9
`define SSRG_B_NORMAL     10
`define SSRG_B_FATAL      11
`define SSRG_B_STEERED    12
// Bit 15 can never be written
`define SSRG_WMASK        16'h7FFF
`define SSRG_ZERO         16'h0000
`define SSRG_ONES         16'h7FFF
// Summary byte bit positions
`define SSRG_SB_QUES      3
`define SSRG_SB_ESB       5
`define SSRG_SB_REQ       6
`define SSRG_SB_OPER      7
`define SSRG_SB_ZERO      8'h00

`endif

//--- hdl/ssrg_top.v
// Operation and questionable status groups with command port and summary byte
// Overview of operation
// - Each group has condition, event, enable, rise filter and fall filter registers.
// - Operation group is 16 bits; only bits 0, 8-12 are live.
// - Questionable group is live only at bits 2, 5 and 6.
// - Reading an event register returns it and clears it.
// - Event set on filtered rising or filtered falling condition edge.
// - Condition read returns live state and changes nothing.
// - Enable write loads value; read returns it unchanged.
// - Fall filter write selects which falling edges are recorded.
// - Rise filter write selects which rising edges are recorded.
// - Written value maps by binary weight; bit 15 can never be set.
// - Any enabled questionable event sets summary byte bit 3.
// - Preset clears enables, sets rise filters, clears fall filters.
// - Any enabled operation event sets summary byte bit 7.
// - Operation condition bits: calibrate, standby, battery, normal, fatal, steered.
// - Active-low status output follows the summary request bit.
`timescale 1ns/1ps
module ssrg_top (
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire        i_ce,
   input  wire        i_calibrating,
   input  wire        i_standby,
   input  wire        i_on_battery,
   input  wire        i_normal,
   input  wire        i_fatal,
   input  wire        i_steered,
   input  wire [15:0] i_ques_cond,
   input  wire        i_init,
   input  wire        i_preset,
   input  wire        i_clear,
   input  wire        i_esb,
   input  wire        i_rd,
   input  wire        i_wr,
   input  wire [3:0]  i_addr,
   input  wire [15:0] i_wdata,
   output reg  [15:0] o_rdata,
   output reg         o_rvalid,
   output reg  [7:0]  o_status_byte,
   output reg         o_status_n
);
`include "ssrg_map.vh"

   // Two-stage synchronisers for pin-level condition inputs
   reg  [15:0] op_meta;
   reg  [15:0] op_sync;
   reg  [15:0] qu_meta;
   reg  [15:0] qu_sync;
   reg  [15:0] op_raw;

   // Unused operation positions stay at zero
   always @* begin
      op_raw                  = `SSRG_ZERO;
      op_raw[`SSRG_B_CAL]     = i_calibrating;
      op_raw[`SSRG_B_STANDBY] = i_standby;
      op_raw[`SSRG_B_BATTERY] = i_on_battery;
      op_raw[`SSRG_B_NORMAL]  = i_normal;
      op_raw[`SSRG_B_FATAL]   = i_fatal;
      op_raw[`SSRG_B_STEERED] = i_steered;
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         op_meta <= `SSRG_ZERO;
         op_sync <= `SSRG_ZERO;
         qu_meta <= `SSRG_ZERO;
         qu_sync <= `SSRG_ZERO;
      end else if (i_ce) begin
         op_meta <= op_raw;
         op_sync <= op_meta;
         qu_meta <= i_ques_cond;
         qu_sync <= qu_meta;
      end
   end

   function sel;
      input [3:0] a;
      input [3:0] r;
      begin
         sel = (a == r);
      end
   endfunction

   wire        rd_go = i_rd & i_ce;
   wire        wr_go = i_wr & i_ce;
   wire [15:0] op_cond, op_event, op_enable, op_fall, op_rise;
   wire [15:0] qu_cond, qu_event, qu_enable, qu_fall, qu_rise;
   wire        op_sum;
   wire        qu_sum;

   ssrg_group #(.LIVE(`SSRG_OP_LIVE)) u_oper (
      .i_sys_clk   (i_sys_clk),
      .i_rst       (i_rst),
      .i_ce        (i_ce),
      .i_cond      (op_sync),
      .i_init      (i_init),
      .i_preset    (i_preset),
      .i_clear     (i_clear),
      .i_ev_read   (rd_go & sel(i_addr, `SSRG_OP_EVENT)),
      .i_wr_enable (wr_go & sel(i_addr, `SSRG_OP_ENABLE)),
      .i_wr_fall   (wr_go & sel(i_addr, `SSRG_OP_FALL)),
      .i_wr_rise   (wr_go & sel(i_addr, `SSRG_OP_RISE)),
      .i_wdata     (i_wdata),
      .o_cond      (op_cond),
      .o_event     (op_event),
      .o_enable    (op_enable),
      .o_fall      (op_fall),
      .o_rise      (op_rise),
      .o_summary   (op_sum)
   );

   ssrg_group #(.LIVE(`SSRG_QU_LIVE)) u_ques (
      .i_sys_clk   (i_sys_clk),
      .i_rst       (i_rst),
      .i_ce        (i_ce),
      .i_cond      (qu_sync),
      .i_init      (i_init),
      .i_preset    (i_preset),
      .i_clear     (i_clear),
      .i_ev_read   (rd_go & sel(i_addr, `SSRG_QU_EVENT)),
      .i_wr_enable (wr_go & sel(i_addr, `SSRG_QU_ENABLE)),
      .i_wr_fall   (wr_go & sel(i_addr, `SSRG_QU_FALL)),
      .i_wr_rise   (wr_go & sel(i_addr, `SSRG_QU_RISE)),
      .i_wdata     (i_wdata),
      .o_cond      (qu_cond),
      .o_event     (qu_event),
      .o_enable    (qu_enable),
      .o_fall      (qu_fall),
      .o_rise      (qu_rise),
      .o_summary   (qu_sum)
   );

   reg [15:0] next_rdata;

   always @* begin
      case (i_addr)
         `SSRG_OP_COND   : next_rdata = op_cond;
         `SSRG_OP_EVENT  : next_rdata = op_event;
         `SSRG_OP_ENABLE : next_rdata = op_enable;
         `SSRG_OP_FALL   : next_rdata = op_fall;
         `SSRG_OP_RISE   : next_rdata = op_rise;
         `SSRG_QU_COND   : next_rdata = qu_cond;
         `SSRG_QU_EVENT  : next_rdata = qu_event;
         `SSRG_QU_ENABLE : next_rdata = qu_enable;
         `SSRG_QU_FALL   : next_rdata = qu_fall;
         `SSRG_QU_RISE   : next_rdata = qu_rise;
         default         : next_rdata = `SSRG_ZERO;
      endcase
   end

   // Request bit mirrors the OR of summaries since no standard-event enable lives here
   wire req = op_sum | qu_sum | i_esb;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata       <= `SSRG_ZERO;
         o_rvalid      <= 1'b0;
         o_status_byte <= `SSRG_SB_ZERO;
         o_status_n    <= 1'b1;
      end else if (i_ce) begin
         o_rvalid <= i_rd;
         if (i_rd) begin
            o_rdata <= next_rdata;
         end
         o_status_byte                <= `SSRG_SB_ZERO;
         o_status_byte[`SSRG_SB_QUES] <= qu_sum;
         o_status_byte[`SSRG_SB_OPER] <= op_sum;
         o_status_byte[`SSRG_SB_ESB]  <= i_esb;
         o_status_byte[`SSRG_SB_REQ]  <= req;
         o_status_n                   <= ~req;
      end
   end
endmodule // ssrg_top

//--- sim/ssrg_ctrl.sv
// Remote controller model issuing status register reads and writes
`timescale 1ns/1ps
module ssrg_ctrl (
   input  wire        i_sys_clk,
   input  wire        i_rvalid,
   input  wire [15:0] i_rdata,
   output reg         o_rd = 1'b0,
   output reg         o_wr = 1'b0,
   output reg  [3:0]  o_addr = 4'h0,
   output reg  [15:0] o_wdata = 16'h0000
);
   // Called at a falling edge; a clock edge passes before the next call
   task wr(input [3:0] a, input [15:0] d);
      begin
         o_addr <= a;
         o_wdata <= d & 16'h7FFF;
         o_wr <= 1'b1;
         @(negedge i_sys_clk);
         o_wr <= 1'b0;
         o_wdata <= ~d;
         @(negedge i_sys_clk);
      end
   endtask
   task rd(input [3:0] a, output [15:0] d, output ok);
      integer n;
      begin
         ok = 1'b0;
         d = 16'h0000;
         o_addr <= a;
         o_rd <= 1'b1;
         @(negedge i_sys_clk);
         o_rd <= 1'b0;
         for (n = 0; n < 4 && !ok; n = n + 1) begin
            if (i_rvalid === 1'b1) begin
               d = i_rdata;
               ok = 1'b1;
            end else
               @(negedge i_sys_clk);
         end
         @(negedge i_sys_clk);
      end
   endtask
endmodule // ssrg_ctrl

//--- sim/ssrg_props.sv
// Assertion checker for the status register groups
`timescale 1ns/1ps
module ssrg_props (
   input wire        i_sys_clk,
   input wire        i_rst,
   input wire        i_ce,
   input wire        i_rd,
   input wire        i_wr,
   input wire        i_init,
   input wire        i_preset,
   input wire [3:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire [15:0] o_rdata,
   input wire        o_rvalid,
   input wire [7:0]  o_status_byte,
   input wire        o_status_n
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence s_rd(a);
      i_ce && i_rd && !i_wr && !i_init && !i_preset && i_addr == a;
   endsequence
   sequence s_wr_en;
      i_ce && i_wr && !i_rd && !i_init && !i_preset && i_addr == 4'h2;
   endsequence
   a_rd_answer: assert property (i_ce && i_rd |=> o_rvalid)
      else $error("read not answered");
   a_rvalid_cause: assert property (o_rvalid |-> $past(i_rd))
      else $error("answer without read");
   a_status_pin: assert property (o_status_n == !o_status_byte[6])
      else $error("status pin wrong");
   a_oper_live: assert property (o_rvalid && $past(i_addr) == 4'h0 |-> (o_rdata & 16'hE0FE) == 16'h0000)
      else $error("dead operation bit set");
   a_ques_live: assert property (o_rvalid && $past(i_addr) == 4'h5 |-> (o_rdata & 16'hFF9B) == 16'h0000)
      else $error("dead questionable bit set");
   a_bit15_clear: assert property (o_rvalid && $past(i_addr) inside {4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9} |-> !o_rdata[15])
      else $error("bit 15 set");
   a_enable_back: assert property (s_wr_en ##1 !i_wr && !i_init && !i_preset ##1 s_rd(4'h2) |=> o_rdata == ($past(i_wdata, 3) & 16'h7FFF))
      else $error("enable readback wrong");
   a_preset_rise: assert property (i_ce && i_preset && !i_init ##1 s_rd(4'h4) |=> o_rdata == 16'h7FFF)
      else $error("preset rise filter wrong");
endmodule // ssrg_props
bind ssrg_top ssrg_props i_ssrg_props (.*);

//--- sim/tb_top.sv
// Testbench for the status register groups
`timescale 1ns/1ps
module tb_top;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [5:0]  opc = 6'h00;
   reg  [15:0] qc = 16'h0000;
   reg         init_p = 1'b0;
   reg         preset_p = 1'b0;
   reg         ce = 1'b1;
   reg         clr_p = 1'b0;
   reg         esb = 1'b0;
   reg  [15:0] rd_d;
   reg         rd_ok;
   wire        rd;
   wire        wr;
   wire [3:0]  addr;
   wire [15:0] wdata;
   wire [15:0] rdata;
   wire        rvalid;
   wire [7:0]  sb;
   wire        st_n;
   integer     miscompares = 0;
   integer     total_checks = 0;
   ssrg_top i_ssrg_top (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_calibrating(opc[0]), .i_standby(opc[1]),
      .i_on_battery(opc[2]), .i_normal(opc[3]), .i_fatal(opc[4]), .i_steered(opc[5]), .i_ques_cond(qc),
      .i_init(init_p), .i_preset(preset_p), .i_clear(clr_p), .i_esb(esb), .i_rd(rd), .i_wr(wr), .i_addr(addr),
      .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_status_byte(sb), .o_status_n(st_n));
   ssrg_ctrl i_ssrg_ctrl (.i_sys_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_rd(rd), .o_wr(wr),
      .o_addr(addr), .o_wdata(wdata));
   always #12.5 clk = ~clk;
   task chk(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task rc(input [3:0] a, input [15:0] exp);
      reg [15:0] d;
      reg        ok;
      begin
         i_ssrg_ctrl.rd(a, d, ok);
         if (!ok) begin
            miscompares = miscompares + 1;
            $display("BAD %0t read timed out", $time);
            conclude;
         end
         chk(d, exp);
      end
   endtask
   // Two sync stages, condition, event and summary all fit in six cycles
   task settle;
      repeat (6) @(negedge clk);
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst <= 1'b0;
      rc(4'h2, 16'h0000);
      i_ssrg_ctrl.wr(4'h2, 16'hFFFF);
      rc(4'h2, 16'h7FFF);
      i_ssrg_ctrl.wr(4'h8, 16'h0040);
      rc(4'h8, 16'h0040);
      i_ssrg_ctrl.wr(4'h4, 16'h0100);
      rc(4'h4, 16'h0100);
      opc <= 6'h3F;
      settle;
      chk({8'h00, sb}, 16'h00C0);
      chk({15'h0000, st_n}, 16'h0000);
      rc(4'h0, 16'h1F01);
      opc <= 6'h00;
      settle;
      rc(4'h1, 16'h0100);
      rc(4'h1, 16'h0000);
      chk({8'h00, sb}, 16'h0000);
      i_ssrg_ctrl.wr(4'h7, 16'h0040);
      qc <= 16'hFFFF;
      settle;
      rc(4'h5, 16'h0064);
      rc(4'h6, 16'h0000);
      qc <= 16'h0000;
      settle;
      chk({8'h00, sb}, 16'h0048);
      rc(4'h6, 16'h0040);
      @(negedge clk) preset_p <= 1'b1;
      @(negedge clk) preset_p <= 1'b0;
      rc(4'h4, 16'h7FFF);
      rc(4'h9, 16'h7FFF);
      rc(4'h7, 16'h0000);
      rc(4'h8, 16'h0000);
      // Two sync edges pass, so the edge lands in the clearing read's cycle
      qc <= 16'h0004;
      repeat (2) @(negedge clk);
      rc(4'h6, 16'h0000);
      rc(4'h6, 16'h0004);
      i_ssrg_ctrl.wr(4'h7, 16'h0020);
      qc <= 16'h0024;
      settle;
      chk({8'h00, sb}, 16'h0048);
      @(negedge clk) clr_p <= 1'b1;
      @(negedge clk) clr_p <= 1'b0;
      settle;
      chk({8'h00, sb}, 16'h0000);
      rc(4'h6, 16'h0000);
      esb <= 1'b1;
      settle;
      chk({8'h00, sb}, 16'h0060);
      chk({15'h0000, st_n}, 16'h0000);
      esb <= 1'b0;
      // A read while the clock enable is low must go unanswered
      @(negedge clk) ce <= 1'b0;
      i_ssrg_ctrl.rd(4'h2, rd_d, rd_ok);
      chk({15'h0000, rd_ok}, 16'h0000);
      @(negedge clk) ce <= 1'b1;
      i_ssrg_ctrl.wr(4'hC, 16'h1234);
      rc(4'hC, 16'h0000);
      @(negedge clk) init_p <= 1'b1;
      @(negedge clk) init_p <= 1'b0;
      rc(4'h4, 16'h0000);
      i_ssrg_ctrl.wr(4'h7, 16'h0055);
      @(negedge clk) rst <= 1'b1;
      repeat (2) @(negedge clk);
      rst <= 1'b0;
      rc(4'h7, 16'h0000);
      conclude;
   end
endmodule // tb_top
